/* core/slq_pkg.sv */
package slq_pkg;

    localparam int unsigned NCOM          = 4;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DIV_W         = 16;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL_A    = 12'h000;
    localparam logic [11:0] OFF_CTRL_B    = 12'h004;
    localparam logic [11:0] OFF_FRAME     = 12'h008;
    localparam logic [11:0] OFF_CONTRAST  = 12'h00c;
    localparam logic [11:0] OFF_ASYNC     = 12'h010;
    localparam logic [11:0] OFF_STATUS    = 12'h014;
    localparam logic [11:0] OFF_MEM_BASE  = 12'h020;
    localparam logic [11:0] OFF_MEM_LAST  = 12'h02c;

    // Control A field positions
    localparam int unsigned BIT_ENABLE    = 7;
    localparam int unsigned BIT_LOW_POWER = 6;
    localparam int unsigned BIT_FLAG      = 4;
    localparam int unsigned BIT_BLANK     = 0;
    // Control B field positions
    localparam int unsigned BIT_CLK_SEL   = 7;
    localparam int unsigned BIT_HALF_BIAS = 6;
    localparam int unsigned POS_DUTY      = 4;
    localparam int unsigned POS_MASK      = 0;
    // Async status field position
    localparam int unsigned BIT_EXT_CLK   = 0;

    // Reset values
    localparam logic [7:0]  RST_CTRL_B    = 8'h00;
    localparam logic [15:0] RST_FRAME     = 16'h0000;
    localparam logic [7:0]  RST_CONTRAST  = 8'h00;

    // Duty encodings
    localparam logic [1:0]  DUTY_STATIC   = 2'h0;

    // Segment count for port mask value m is SEG_BASE + 2*m
    localparam logic [5:0]  SEG_BASE      = 6'h0d;

    // Drive level codes; with half bias LVL_LOW means the mid level
    localparam logic [1:0]  LVL_GND       = 2'h0;
    localparam logic [1:0]  LVL_LOW       = 2'h1;
    localparam logic [1:0]  LVL_HIGH      = 2'h2;
    localparam logic [1:0]  LVL_VLCD      = 2'h3;

    typedef enum logic [2:0] {
        SLP_ACTIVE,
        SLP_IDLE,
        SLP_ADC_NR,
        SLP_POWER_DOWN,
        SLP_POWER_SAVE,
        SLP_STANDBY
    } slq_sleep_t;

    typedef struct packed {
        logic       clk_sel;
        logic       half_bias;
        logic [1:0] duty;
        logic [3:0] pin_mask;
    } slq_cfg_t;

    typedef struct packed {
        logic       low_power;
        logic       blank;
        logic [7:0] contrast;
    } slq_latch_t;

endpackage

/* core/slq_sync.sv */
`timescale 1ns/1ns
module slq_sync #(
    parameter int unsigned STAGES = 3
) (
    input  wire logic clk_i,
    input  wire logic rst_ni,
    input  wire logic d_i,
    output logic      tap_o,
    output logic      q_o
);
    logic [STAGES-1:0] chain_q;
    logic [STAGES-1:0] chain_d;

    always_comb
    begin
        chain_d = {chain_q[STAGES-2:0], d_i};
    end

    always_ff @(posedge clk_i or negedge rst_ni)
    begin
        if (!rst_ni)
        begin
            chain_q <= '0;
        end
        else
        begin
            chain_q <= chain_d;
        end
    end

    // Tap is the second-to-last stage, never the first one for three stages
    assign tap_o = chain_q[STAGES-2];
    assign q_o   = chain_q[STAGES-1];
endmodule

/* core/slq_frame_sequencer.sv */
`timescale 1ns/1ns
// Behaviour
// - Low-power bit selects low-power waveform else default
// - Low-power mode holds data two frames
// - Low-power latches and flags every second frame
// - Static, 1/2, 1/3, 1/4 duty supported
// - Half or third bias selectable when multiplexed
// - Synchronous clock runs in idle, power-save
// - Async clock with RC adds noise-reduction mode
// - External clock buffer enabled with async select
// - Blanking grounds all pins after current frame
// - Display memory kept intact during blanking
// - Masked segment pins revert to port function
// - Unused commons revert to port automatically
// - Latch memory, blank, waveform, contrast per frame
// - Writes accepted anytime; updates may split frames
// - Memory bit one energizes segment
// - Extra intermediate levels per bias choice
// - Flag set at frame latch, write one clears
// - Duty field encodes 00,01,10,11
module slq_frame_sequencer
    import slq_pkg::*;
#(
    parameter int unsigned NSEG = 25
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [ADDR_W-1:0]     paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  timer_osc_input_pin_i,
    input  wire slq_sleep_t            sleep_mode_i,
    input  wire logic                  sys_clk_rc_i,
    output logic [NCOM-1:0][1:0]       com_level_o,
    output logic [NSEG-1:0][1:0]       seg_level_o,
    output logic [NCOM-1:0]            com_lcd_en_o,
    output logic [NSEG-1:0]            seg_lcd_en_o,
    output logic [7:0]                 contrast_o,
    output logic                       ext_clk_buf_en_o,
    output logic                       running_o,
    output logic                       frame_start_flag_o
);
    typedef enum logic {SQ_OFF, SQ_RUN} slq_state_t;

    logic rst_n;
    logic tosc_tap;
    logic tosc_q;

    slq_sync #(.STAGES(2)) u_rst_sync (
        .clk_i  (clk_i),
        .rst_ni (resetn_i),
        .d_i    (1'b1),
        .tap_o  (),
        .q_o    (rst_n)
    );

    slq_sync #(.STAGES(3)) u_tosc_sync (
        .clk_i  (clk_i),
        .rst_ni (rst_n),
        .d_i    (timer_osc_input_pin_i),
        .tap_o  (tosc_tap),
        .q_o    (tosc_q)
    );

    // Register group
    logic             enable_q, enable_d;
    logic             low_power_wave_select_q, low_power_wave_select_d;
    logic             blank_request_q, blank_request_d;
    logic             frame_start_flag_q, frame_start_flag_d;
    slq_cfg_t         cfg_q, cfg_d;
    logic [DIV_W-1:0] frame_rate_q, frame_rate_d;
    logic [7:0]       contrast_q, contrast_d;
    logic             ext_clk_en_q, ext_clk_en_d;
    logic [NSEG-1:0]  mem_q [NCOM];
    logic [NSEG-1:0]  mem_d [NCOM];
    logic             pready_q, pready_d;
    logic             pslverr_q, pslverr_d;
    logic [31:0]      prdata_q, prdata_d;

    // Sequencer group
    slq_state_t       st_q, st_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [1:0]       com_q, com_d;
    logic             half_q, half_d;
    logic             pair_q, pair_d;
    logic             tosc_lvl_q, tosc_lvl_d;
    slq_latch_t       lat_q, lat_d;
    logic [NSEG-1:0]  lmem_q [NCOM];
    logic [NSEG-1:0]  lmem_d [NCOM];
    logic             frame_latch;
    logic             run_ok;
    logic             tick;

    // Output group
    logic [NCOM-1:0][1:0] com_level_d;
    logic [NSEG-1:0][1:0] seg_level_d;
    logic [NCOM-1:0]      com_en_d;
    logic [NSEG-1:0]      seg_en_d;
    logic                 ext_buf_d;
    logic                 running_d;

    logic access;
    logic mem_hit;
    logic [11:0] word_addr;

    always_comb
    begin
        access    = psel_i & penable_i & pready_q;
        word_addr = {paddr_i[11:2], 2'b00};
        mem_hit   = (word_addr >= OFF_MEM_BASE) && (word_addr <= OFF_MEM_LAST);
        enable_d                = enable_q;
        low_power_wave_select_d = low_power_wave_select_q;
        blank_request_d         = blank_request_q;
        cfg_d                   = cfg_q;
        frame_rate_d            = frame_rate_q;
        contrast_d              = contrast_q;
        ext_clk_en_d            = ext_clk_en_q;
        mem_d                   = mem_q;
        frame_start_flag_d      = frame_start_flag_q;
        // One wait state so read data leaves a flip-flop
        pready_d  = psel_i & penable_i & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (pready_d)
        begin
            pslverr_d = 1'b1;
            if (mem_hit)
            begin
                pslverr_d = 1'b0;
                prdata_d[NSEG-1:0] = mem_q[word_addr[3:2]];
            end
            else
            begin
                case (word_addr)
                    OFF_CTRL_A:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[BIT_ENABLE]    = enable_q;
                        prdata_d[BIT_LOW_POWER] = low_power_wave_select_q;
                        prdata_d[BIT_FLAG]      = frame_start_flag_q;
                        prdata_d[BIT_BLANK]     = blank_request_q;
                    end
                    OFF_CTRL_B:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[7:0] = cfg_q;
                    end
                    OFF_FRAME:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[DIV_W-1:0] = frame_rate_q;
                    end
                    OFF_CONTRAST:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[7:0] = contrast_q;
                    end
                    OFF_ASYNC:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[BIT_EXT_CLK] = ext_clk_en_q;
                    end
                    OFF_STATUS:
                    begin
                        pslverr_d = 1'b0;
                        prdata_d[4:0] = {st_q == SQ_RUN, com_q, lat_q.blank, lat_q.low_power};
                    end
                    default:
                    begin
                        pslverr_d = 1'b1;
                    end
                endcase
            end
        end
        // Writes land at any time; latching only samples them at frame start
        if (access && pwrite_i)
        begin
            if (mem_hit)
            begin
                mem_d[word_addr[3:2]] = pwdata_i[NSEG-1:0];
            end
            else
            begin
                case (word_addr)
                    OFF_CTRL_A:
                    begin
                        enable_d                = pwdata_i[BIT_ENABLE];
                        low_power_wave_select_d = pwdata_i[BIT_LOW_POWER];
                        blank_request_d         = pwdata_i[BIT_BLANK];
                        if (pwdata_i[BIT_FLAG])
                        begin
                            frame_start_flag_d = 1'b0;
                        end
                    end
                    OFF_CTRL_B:   cfg_d        = pwdata_i[7:0];
                    OFF_FRAME:    frame_rate_d = pwdata_i[DIV_W-1:0];
                    OFF_CONTRAST: contrast_d   = pwdata_i[7:0];
                    OFF_ASYNC:    ext_clk_en_d = pwdata_i[BIT_EXT_CLK];
                    default:      enable_d     = enable_q;
                endcase
            end
        end
        // Set beats a same-cycle clear
        if (frame_latch)
        begin
            frame_start_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q                <= 1'b0;
            low_power_wave_select_q <= 1'b0;
            blank_request_q         <= 1'b0;
            frame_start_flag_q      <= 1'b0;
            cfg_q                   <= RST_CTRL_B;
            frame_rate_q            <= RST_FRAME;
            contrast_q              <= RST_CONTRAST;
            ext_clk_en_q            <= 1'b0;
            mem_q                   <= '{default: '0};
            pready_q                <= 1'b0;
            pslverr_q               <= 1'b0;
            prdata_q                <= 32'h0000_0000;
        end
        else
        begin
            enable_q                <= enable_d;
            low_power_wave_select_q <= low_power_wave_select_d;
            blank_request_q         <= blank_request_d;
            frame_start_flag_q      <= frame_start_flag_d;
            cfg_q                   <= cfg_d;
            frame_rate_q            <= frame_rate_d;
            contrast_q              <= contrast_d;
            ext_clk_en_q            <= ext_clk_en_d;
            mem_q                   <= mem_d;
            pready_q                <= pready_d;
            pslverr_q               <= pslverr_d;
            prdata_q                <= prdata_d;
        end
    end

    // Sleep mode gating; deep modes rely on software disabling first
    always_comb
    begin
        case (sleep_mode_i)
            SLP_ACTIVE:     run_ok = 1'b1;
            SLP_IDLE:       run_ok = 1'b1;
            SLP_POWER_SAVE: run_ok = 1'b1;
            SLP_ADC_NR:     run_ok = cfg_q.clk_sel & sys_clk_rc_i;
            default:        run_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        tosc_lvl_d = (tosc_tap == tosc_q) ? tosc_q : tosc_lvl_q;
        tick       = cfg_q.clk_sel ? (tosc_tap & tosc_q & ~tosc_lvl_q) : 1'b1;
        st_d        = st_q;
        div_d       = div_q;
        com_d       = com_q;
        half_d      = half_q;
        pair_d      = pair_q;
        lat_d       = lat_q;
        lmem_d      = lmem_q;
        frame_latch = 1'b0;
        case (st_q)
            SQ_OFF:
            begin
                if (enable_q && run_ok)
                begin
                    st_d        = SQ_RUN;
                    div_d       = '0;
                    com_d       = 2'h0;
                    half_d      = 1'b0;
                    pair_d      = 1'b0;
                    frame_latch = 1'b1;
                end
            end
            SQ_RUN:
            begin
                if (!enable_q)
                begin
                    st_d = SQ_OFF;
                end
                else if (tick && run_ok)
                begin
                    if (div_q != frame_rate_q)
                    begin
                        div_d = div_q + 1'b1;
                    end
                    else
                    begin
                        div_d = '0;
                        if (!lat_q.low_power && !half_q)
                        begin
                            half_d = 1'b1;
                        end
                        else
                        begin
                            half_d = 1'b0;
                            if (com_q == cfg_q.duty)
                            begin
                                com_d = 2'h0;
                                if (lat_q.low_power && !pair_q)
                                begin
                                    pair_d = 1'b1;
                                end
                                else
                                begin
                                    pair_d      = 1'b0;
                                    frame_latch = 1'b1;
                                end
                            end
                            else
                            begin
                                com_d = com_q + 2'h1;
                            end
                        end
                    end
                end
            end
            default:
            begin
                st_d = SQ_OFF;
            end
        endcase
        if (frame_latch)
        begin
            lat_d  = '{low_power: low_power_wave_select_q, blank: blank_request_q, contrast: contrast_q};
            lmem_d = mem_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q       <= SQ_OFF;
            div_q      <= '0;
            com_q      <= 2'h0;
            half_q     <= 1'b0;
            pair_q     <= 1'b0;
            tosc_lvl_q <= 1'b0;
            lat_q      <= '0;
            lmem_q     <= '{default: '0};
        end
        else
        begin
            st_q       <= st_d;
            div_q      <= div_d;
            com_q      <= com_d;
            half_q     <= half_d;
            pair_q     <= pair_d;
            tosc_lvl_q <= tosc_lvl_d;
            lat_q      <= lat_d;
            lmem_q     <= lmem_d;
        end
    end

    // Pin levels; low-power flips polarity per frame, default per half slot
    logic       pol;
    logic [1:0] sel_lvl;
    logic [1:0] anti_lvl;
    logic [1:0] idle_com;
    logic [1:0] off_seg;
    logic [5:0] seg_cnt;

    always_comb
    begin
        running_d = (st_q == SQ_RUN);
        ext_buf_d = ext_clk_en_q & cfg_q.clk_sel;
        pol       = lat_q.low_power ? pair_q : half_q;
        sel_lvl   = pol ? LVL_GND : LVL_VLCD;
        anti_lvl  = pol ? LVL_VLCD : LVL_GND;
        idle_com  = cfg_q.half_bias ? LVL_LOW : (pol ? LVL_HIGH : LVL_LOW);
        off_seg   = (cfg_q.half_bias || cfg_q.duty == DUTY_STATIC) ? sel_lvl
                    : (pol ? LVL_LOW : LVL_HIGH);
        seg_cnt   = SEG_BASE + {1'b0, cfg_q.pin_mask, 1'b0};
        for (int c = 0; c < NCOM; c++)
        begin
            com_en_d[c]    = running_d && (2'(c) <= cfg_q.duty);
            com_level_d[c] = LVL_GND;
            if (com_en_d[c] && !lat_q.blank)
            begin
                com_level_d[c] = (2'(c) == com_q) ? sel_lvl : idle_com;
            end
        end
        for (int s = 0; s < NSEG; s++)
        begin
            seg_en_d[s]    = running_d && (6'(s) < seg_cnt);
            seg_level_d[s] = LVL_GND;
            if (seg_en_d[s] && !lat_q.blank)
            begin
                seg_level_d[s] = lmem_q[com_q][s] ? anti_lvl : off_seg;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            com_level_o        <= '0;
            seg_level_o        <= '0;
            com_lcd_en_o       <= '0;
            seg_lcd_en_o       <= '0;
            contrast_o         <= RST_CONTRAST;
            ext_clk_buf_en_o   <= 1'b0;
            running_o          <= 1'b0;
            frame_start_flag_o <= 1'b0;
        end
        else
        begin
            com_level_o        <= com_level_d;
            seg_level_o        <= seg_level_d;
            com_lcd_en_o       <= com_en_d;
            seg_lcd_en_o       <= seg_en_d;
            contrast_o         <= lat_q.contrast;
            ext_clk_buf_en_o   <= ext_buf_d;
            running_o          <= running_d;
            frame_start_flag_o <= frame_start_flag_q;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
endmodule

/* verification/slq_frame_sequencer_checker.sv */
`timescale 1ns/1ns
module slq_frame_sequencer_checker
    import slq_pkg::*;
#(
    parameter int unsigned NSEG = 25
) (
    input wire logic                 clk_i,
    input wire logic                 resetn_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire logic [NCOM-1:0][1:0] com_level_o,
    input wire logic [NCOM-1:0]      com_lcd_en_o,
    input wire logic [NSEG-1:0]      seg_lcd_en_o,
    input wire logic                 running_o,
    input wire logic                 frame_start_flag_o
);
    logic [NCOM-1:0] com_lit;
    logic [NCOM-1:0] com_peak;
    // Blanked frames put every common at ground, so only live frames count
    always_comb
    begin
        for (int i = 0; i < NCOM; i++)
        begin
            com_lit[i]  = com_lcd_en_o[i] && com_level_o[i] != LVL_GND;
            com_peak[i] = com_lcd_en_o[i] && com_level_o[i][0] == com_level_o[i][1];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_ready_wait;
        psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_ready;
        pslverr_o |-> pready_o && $past(psel_i && penable_i);
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_com_shape;
        ((com_lcd_en_o + 1'b1) & com_lcd_en_o) == '0;
    endproperty
    a_com_shape: assert property (p_com_shape) else $error("commons not from zero");
    property p_seg_shape;
        ((seg_lcd_en_o + 1'b1) & seg_lcd_en_o) == '0 && (seg_lcd_en_o == '0 || &seg_lcd_en_o[12:0]);
    endproperty
    a_seg_shape: assert property (p_seg_shape) else $error("segment mask shape");
    property p_one_sel;
        (|com_lit) |-> $countones(com_peak) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two commons selected");
    property p_flag_run;
        $rose(frame_start_flag_o) |-> running_o || $past(running_o);
    endproperty
    a_flag_run: assert property (p_flag_run) else $error("flag while off");
    property p_off_port;
        $fell(running_o) |-> ##[0:2] (com_lcd_en_o == '0 && seg_lcd_en_o == '0);
    endproperty
    a_off_port: assert property (p_off_port) else $error("pins kept after off");
    c_err: cover property (pready_o && pslverr_o);
    c_flag: cover property ($rose(frame_start_flag_o));
    c_off: cover property ($fell(running_o));
endmodule
bind slq_frame_sequencer slq_frame_sequencer_checker #(.NSEG(NSEG)) slq_frame_sequencer_checker_inst (.*);

/* verification/slq_panel_model.sv */
`timescale 1ns/1ns
module slq_panel_model
    import slq_pkg::*;
#(
    parameter int unsigned NSEG = 25
) (
    input  wire logic                 clk_i,
    input  wire logic                 clr_i,
    input  wire logic [NCOM-1:0][1:0] com_level_i,
    input  wire logic [NSEG-1:0][1:0] seg_level_i,
    output logic      [NCOM-1:0]      full_o
);
    // Cell on segment zero darkens only under a full swing
    always @(posedge clk_i)
    begin
        for (int i = 0; i < NCOM; i++)
        begin
            if (clr_i)
                full_o[i] <= 1'b0;
            else if ((com_level_i[i] ^ seg_level_i[0]) == LVL_VLCD && com_level_i[i][0] == com_level_i[i][1])
                full_o[i] <= 1'b1;
        end
    end
endmodule

/* verification/tb_slq_frame_sequencer.sv */
`timescale 1ns/1ns
module tb_slq_frame_sequencer;
    import slq_pkg::*;
    localparam int unsigned NSEG = 25;
    logic                 clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [ADDR_W-1:0]    paddr_i;
    logic [31:0]          pwdata_i, prdata_o, rdat, cta;
    logic [31:0]          mem [NCOM];
    slq_sleep_t           sleep_mode_i;
    logic [NCOM-1:0][1:0] com_level_o;
    logic [NSEG-1:0][1:0] seg_level_o;
    logic [NCOM-1:0]      com_lcd_en_o, full;
    logic [NSEG-1:0]      seg_lcd_en_o;
    logic [7:0]           contrast_o, ctr;
    logic [1:0]           tck = '0;
    logic                 ext_clk_buf_en_o, running_o, frame_start_flag_o, sys_clk_rc_i, rerr, clr, rb, ex;
    wire logic            timer_osc_input_pin_i;
    int                   mismatches, n_compared, seed, m;
    assign timer_osc_input_pin_i = tck[1];
    slq_frame_sequencer #(.NSEG(NSEG)) slq_frame_sequencer_inst (.*);
    slq_panel_model #(.NSEG(NSEG)) slq_panel_model_inst (.clk_i(clk_i), .clr_i(clr),
        .com_level_i(com_level_o), .seg_level_i(seg_level_o), .full_o(full));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) tck <= tck + 2'd1;
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bail();
        mismatches++;
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ones(input int n);
        return 32'((64'h1 << n) - 64'h1);
    endfunction
    function automatic logic exp_run(input int cs, input logic r, input int md);
        return md == SLP_ACTIVE || md == SLP_IDLE || md == SLP_POWER_SAVE || (md == SLP_ADC_NR && cs == 1 && r);
    endfunction
    // Edge between transfers keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50)
            bail();
    endtask
    task automatic rc_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Waits k latches, clearing the sticky flag each time
    task automatic frame(input int k);
        int n;
        repeat (k)
        begin
            n = 0;
            while (frame_start_flag_o !== 1'b1 && n < 500)
            begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 500)
                bail();
            apb(1'b1, OFF_CTRL_A, cta | 32'h10);
            repeat (2) @(posedge clk_i);
        end
    endtask
    task automatic full_chk(input int d);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        frame(3);
        chk(32'(full) & ones(d + 1), {28'h0, mem[3][0], mem[2][0], mem[1][0], mem[0][0]} & ones(d + 1));
    endtask
    initial
    begin
        seed = 32'h79fa1fa4;
        {resetn_i, psel_i, penable_i, pwrite_i, clr, sys_clk_rc_i} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        sleep_mode_i = SLP_ACTIVE;
        cta = '0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rc_chk(OFF_CTRL_B, {24'h0, RST_CTRL_B});
        rc_chk(OFF_CONTRAST, {24'h0, RST_CONTRAST});
        rc_chk(OFF_STATUS, 32'h0);
        rc_chk(12'h018, 32'h0);
        chk(rerr, 1'b1);
        for (int i = 0; i < NCOM; i++)
        begin
            mem[i] = $random(seed) & ones(NSEG);
            apb(1'b1, OFF_MEM_BASE + 12'(4 * i), mem[i]);
        end
        apb(1'b1, OFF_FRAME, 32'h1);
        for (int d = 0; d < 4; d++)
        begin
            m = $unsigned($random(seed)) % 7;
            apb(1'b1, OFF_CTRL_B, 32'((m % 2) << 6 | d << 4 | m));
            cta = 32'h80;
            apb(1'b1, OFF_CTRL_A, cta);
            frame(2);
            chk(running_o, 1'b1);
            chk(32'(com_lcd_en_o), ones(d + 1));
            chk(32'(seg_lcd_en_o), ones(SEG_BASE + 2 * m));
            full_chk(d);
            cta = 32'h0;
            apb(1'b1, OFF_CTRL_A, cta);
        end
        apb(1'b1, OFF_CTRL_B, 32'h80);
        apb(1'b1, OFF_ASYNC, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(ext_clk_buf_en_o, 1'b1);
        apb(1'b1, OFF_CTRL_B, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(ext_clk_buf_en_o, 1'b0);
        cta = 32'h81;
        apb(1'b1, OFF_CTRL_A, cta);
        frame(3);
        chk(32'(|{com_level_o, seg_level_o}), 32'h0);
        rc_chk(OFF_STATUS, 32'h12);
        for (int i = 0; i < NCOM; i++)
            rc_chk(OFF_MEM_BASE + 12'(4 * i), mem[i]);
        ctr = 8'($random(seed));
        apb(1'b1, OFF_CONTRAST, {24'h0, ctr});
        cta = 32'hc0;
        apb(1'b1, OFF_CTRL_A, cta);
        full_chk(0);
        chk(contrast_o, ctr);
        rc_chk(OFF_STATUS, 32'h11);
        cta = 32'h0;
        apb(1'b1, OFF_CTRL_A, cta);
        for (int cs = 0; cs < 2; cs++)
            for (int md = 0; md < 6; md++)
            begin
                rb = 1'($random(seed));
                ex = exp_run(cs, rb, md);
                sys_clk_rc_i <= rb;
                apb(1'b1, OFF_CTRL_B, 32'(cs << 7));
                cta = (ex || cs == 1) ? 32'h80 : 32'h0;
                apb(1'b1, OFF_CTRL_A, cta);
                sleep_mode_i <= slq_sleep_t'(md);
                apb(1'b1, OFF_CTRL_A, cta | 32'h10);
                repeat (100) @(posedge clk_i);
                chk(frame_start_flag_o, ex);
                sleep_mode_i <= SLP_ACTIVE;
                cta = 32'h0;
                apb(1'b1, OFF_CTRL_A, cta);
            end
        tally_and_finish();
    end
endmodule
